/* File: common/frame_encoder_defines.vh */
// constants for the escaped binary reply frame encoder
`ifndef FRAME_ENCODER_DEFINES_VH
`define FRAME_ENCODER_DEFINES_VH
`define FRAME_START_BYTE 8'h1A
`define TYPE_MODE_AC 8'h31
`define TYPE_MODE_S_SHORT 8'h32
`define TYPE_MODE_S_LONG 8'h33
`define NO_STRENGTH_BYTE 8'hFF
`define NO_TIME_BYTE 8'h00
`define TIME_BYTES 6
`define LEN_MODE_AC 5'h02
`define LEN_MODE_S_SHORT 5'h07
`define LEN_MODE_S_LONG 5'h0E
`define KIND_MODE_AC 2'h0
`define KIND_MODE_S_SHORT 2'h1
`define KIND_MODE_S_LONG 2'h2
`define CLK_HZ 50000000
`define TICK_HZ 12000000
`define TICK_ACCUM_STEP 6'h0C
`define CLK_ACCUM_STEP 6'h32
`define TIMER_WIDTH 48
`endif

/* File: hw/skid_buffer.v */
// two-entry valid/ready buffer
`timescale 1ns/1ps
module skid_buffer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] store [0:1];
  reg rdIdx;
  reg wrIdx;
  reg [1:0] count;
  wire push;
  wire pop;

  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = store[rdIdx];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always @(posedge clk) begin
    if (!rst_n) begin
      rdIdx <= 1'b0;
      wrIdx <= 1'b0;
      count <= 2'h0;
      store[0] <= {WIDTH{1'b0}};
      store[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        store[wrIdx] <= inData;
        wrIdx <= ~wrIdx;
      end
      if (pop) begin
        rdIdx <= ~rdIdx;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule

/* File: hw/reply_frame_encoder.v */
// escaped binary frame encoder for received transponder replies
`timescale 1ns/1ps
`include "frame_encoder_defines.vh"
// Behaviour
// - double every 0x1A after the start byte
// - output buffer never drops a doubled byte
// - start byte, type, six timestamp bytes
// - short Mode-S: 0x32, strength, seven bytes
// - long Mode-S: 0x33, strength, fourteen bytes
// - 12 MHz timestamp sampled at reception, MSB first
// - timestamp counter free-running, never aligned
// - no timestamp: six zero bytes
// - no strength: send 0xFF
// - squawk packed as four 3-bit nibble groups
module reply_frame_encoder #(
  parameter TIMER_WIDTH = `TIMER_WIDTH
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // reply input
  input wire replyValid,
  output wire replyReady,
  input wire [1:0] replyKind,
  input wire [111:0] replyData,
  input wire [11:0] squawk,
  input wire [7:0] strength,
  input wire strengthKnown,
  input wire timeKnown,
  // byte stream output
  output wire byteValid,
  input wire byteReady,
  output wire [7:0] byteData,
  // free-running timer view
  output wire [TIMER_WIDTH-1:0] timerValue
);
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BODY = 2'h2;
  localparam ST_DOUBLE = 2'h3;
  localparam [5:0] TICK_STEP = `TICK_ACCUM_STEP;
  localparam [5:0] CLK_STEP = `CLK_ACCUM_STEP;

  reg [1:0] state;
  reg [TIMER_WIDTH-1:0] timer;
  reg [5:0] phase;
  reg [TIMER_WIDTH-1:0] stamp;
  reg [7:0] typeCode;
  reg [7:0] level;
  reg [111:0] payload;
  reg [4:0] dataLen;
  reg [4:0] index;
  reg [4:0] lastIndex;
  reg [7:0] curByte;
  reg [7:0] bufIn;
  reg bufValid;
  wire bufReady;
  wire [15:0] acWord;
  wire [6:0] next_phase;
  wire [2:0] stampSlot;
  wire [4:0] dataSlot;

  // 12 MHz tick from 50 MHz by fractional accumulation
  assign next_phase = {1'b0, phase} + {1'b0, TICK_STEP};
  always @(posedge clk) begin
    if (!rst_n) begin
      phase <= 6'h00;
      timer <= {TIMER_WIDTH{1'b0}};
    end else if (next_phase >= {1'b0, CLK_STEP}) begin
      phase <= next_phase[5:0] - CLK_STEP;
      timer <= timer + {{(TIMER_WIDTH-1){1'b0}}, 1'b1};
    end else begin
      phase <= next_phase[5:0];
    end
  end
  assign timerValue = timer;

  // squawk groups A..D in low three bits of each nibble
  assign acWord = {1'b0, squawk[11:9], 1'b0, squawk[8:6],
                   1'b0, squawk[5:3], 1'b0, squawk[2:0]};
  assign replyReady = (state == ST_IDLE);

  // byte index: 0 type, 1..6 time, 7 strength, 8.. data
  assign stampSlot = 3'h6 - index[2:0];
  assign dataSlot = 5'h15 - index;
  always @* begin
    curByte = 8'h00;
    if (index == 5'h00) begin
      curByte = typeCode;
    end else if (index <= 5'h06) begin
      curByte = stamp[{stampSlot, 3'h0} +: 8];
    end else if (index == 5'h07) begin
      curByte = level;
    end else begin
      curByte = payload[{dataSlot[3:0], 3'h0} +: 8];
    end
  end

  always @* begin
    bufValid = 1'b0;
    bufIn = curByte;
    case (state)
      ST_START: begin
        bufValid = 1'b1;
        bufIn = `FRAME_START_BYTE;
      end
      ST_BODY: begin
        bufValid = 1'b1;
      end
      ST_DOUBLE: begin
        bufValid = 1'b1;
        bufIn = `FRAME_START_BYTE;
      end
      default: begin
        bufValid = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      stamp <= {TIMER_WIDTH{1'b0}};
      typeCode <= 8'h00;
      level <= 8'h00;
      payload <= 112'h0;
      dataLen <= 5'h00;
      index <= 5'h00;
      lastIndex <= 5'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (replyValid) begin
            stamp <= timeKnown ? timer : {TIMER_WIDTH{1'b0}};
            level <= strengthKnown ? strength : `NO_STRENGTH_BYTE;
            index <= 5'h00;
            state <= ST_START;
            case (replyKind)
              `KIND_MODE_AC: begin
                typeCode <= `TYPE_MODE_AC;
                payload <= {acWord, 96'h0};
                lastIndex <= 5'h07 + `LEN_MODE_AC;
              end
              `KIND_MODE_S_SHORT: begin
                typeCode <= `TYPE_MODE_S_SHORT;
                payload <= {replyData[55:0], 56'h0};
                lastIndex <= 5'h07 + `LEN_MODE_S_SHORT;
              end
              default: begin
                typeCode <= `TYPE_MODE_S_LONG;
                payload <= replyData;
                lastIndex <= 5'h07 + `LEN_MODE_S_LONG;
              end
            endcase
          end
        end
        ST_START: begin
          if (bufReady) begin
            state <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (bufReady) begin
            if (curByte == `FRAME_START_BYTE) begin
              state <= ST_DOUBLE;
            end else if (index == lastIndex) begin
              state <= ST_IDLE;
            end else begin
              index <= index + 5'h01;
            end
          end
        end
        ST_DOUBLE: begin
          if (bufReady) begin
            if (index == lastIndex) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_BODY;
              index <= index + 5'h01;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // stalls here hold the encoder, so no escaped byte is lost
  skid_buffer #(
    .WIDTH(8)
  ) outBuffer (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(bufValid),
    .inReady(bufReady),
    .inData(bufIn),
    .outValid(byteValid),
    .outReady(byteReady),
    .outData(byteData)
  );
endmodule

/* File: tb/reply_frame_encoder_checker.sv */
// port assertions for the reply frame encoder
`timescale 1ns/1ps
module reply_frame_encoder_checker #(parameter TIMER_WIDTH = 48) (
  input wire clk,
  input wire rst_n,
  input wire replyValid,
  input wire replyReady,
  input wire [1:0] replyKind,
  input wire byteValid,
  input wire byteReady,
  input wire [7:0] byteData,
  input wire [TIMER_WIDTH-1:0] timerValue
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire take = replyValid && replyReady;
  wire pop = byteValid && byteReady;
  reg [4:0] up;
  reg odd;
  always @(posedge clk) begin
    up <= rst_n ? up + {4'h0, ~&up} : 5'h00;
    odd <= !rst_n ? 1'b0 : pop ? byteData == 8'h1A && !odd : odd;
  end
  a_hold_byte: assert property (byteValid && !byteReady |=> byteValid && $stable(byteData))
    else $error("stall");
  a_start_first: assert property (take && !byteValid |=> ##1 byteValid && byteData == 8'h1A)
    else $error("start");
  a_busy_frame: assert property (take |=> !replyReady)
    else $error("busy");
  a_timer_step: assert property (timerValue - $past(timerValue) <= 1)
    else $error("step");
  a_timer_rate: assert property (&up |-> timerValue - $past(timerValue, 25) == 6)
    else $error("rate");
  a_escape_pair: assert property (pop && odd && byteData != 8'h1A |->
    byteData inside {8'h31, 8'h32, 8'h33})
    else $error("escape");
  a_long_frame: assert property (take && replyKind[1] |=> !replyReady [*8])
    else $error("long");
  a_squawk_frame: assert property (take && replyKind == 2'h0 |=> !replyReady [*4])
    else $error("squawk");
  cover property (pop && odd);
  cover property (byteValid && !byteReady);
  cover property (take && replyKind == 2'h0);
  cover property (take && replyKind[1]);
endmodule
bind reply_frame_encoder reply_frame_encoder_checker #(.TIMER_WIDTH(TIMER_WIDTH)) chk (
  .clk(clk), .rst_n(rst_n), .replyValid(replyValid), .replyReady(replyReady),
  .replyKind(replyKind), .byteValid(byteValid), .byteReady(byteReady),
  .byteData(byteData), .timerValue(timerValue));

/* File: tb/host_receiver.sv */
// host model: stalls at random and unescapes the byte stream into q
`timescale 1ns/1ps
module host_receiver (
  input wire clk,
  input wire byteValid,
  input wire [7:0] byteData,
  output reg byteReady
);
  logic [7:0] q[$];
  bit esc;
  int frames = 0;
  initial byteReady = 1'b0;
  always @(posedge clk) begin
    if (byteValid && byteReady) begin
      if (esc && byteData inside {8'h31, 8'h32, 8'h33}) frames++;
      if (esc || byteData != 8'h1A) q.push_back(byteData);
      esc = !esc && byteData == 8'h1A;
    end
    byteReady <= $urandom % 3 != 0;
  end
endmodule

/* File: tb/reply_frame_encoder_tb.sv */
// self-checking bench for the reply frame encoder
`timescale 1ns/1ps
module reply_frame_encoder_tb;
  reg clk = 1'b0, rst_n = 1'b0, replyValid = 1'b0, strengthKnown = 1'b0, timeKnown = 1'b0;
  reg [1:0] replyKind = 2'h0;
  reg [111:0] replyData = 112'h0;
  reg [11:0] squawk = 12'h000;
  reg [7:0] strength = 8'h00;
  reg [47:0] cyc = 48'h0;
  wire replyReady, byteValid, byteReady;
  wire [7:0] byteData;
  wire [47:0] timerValue;
  bit hung = 1'b0;
  int n_fail = 0, comparisons = 0;
  reply_frame_encoder DUT (.clk(clk), .rst_n(rst_n), .replyValid(replyValid),
    .replyReady(replyReady), .replyKind(replyKind), .replyData(replyData), .squawk(squawk),
    .strength(strength), .strengthKnown(strengthKnown), .timeKnown(timeKnown),
    .byteValid(byteValid), .byteReady(byteReady), .byteData(byteData),
    .timerValue(timerValue));
  host_receiver HOST (.clk(clk), .byteValid(byteValid), .byteData(byteData),
    .byteReady(byteReady));
  initial forever #10 clk = ~clk;
  always @(posedge clk) cyc <= rst_n ? cyc + 48'h1 : 48'h0;
  task automatic results;
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [47:0] g, x);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask
  function automatic logic [7:0] dataByte(input int k, input logic [111:0] d, input int i);
    if (k == 0) return i ? {1'b0, d[5:3], 1'b0, d[2:0]} : {1'b0, d[11:9], 1'b0, d[8:6]};
    return k == 1 ? d[55 - 8 * i -: 8] : d[111 - 8 * i -: 8];
  endfunction
  task automatic frame(input int k, input logic [127:0] d, input logic [7:0] s);
    int n, i;
    logic [47:0] g, t;
    n = k == 0 ? 2 : k == 1 ? 7 : 14;
    @(posedge clk);
    replyKind <= k[1:0];
    replyData <= d[111:0];
    squawk <= d[11:0];
    strength <= s;
    strengthKnown <= $urandom % 2;
    timeKnown <= $urandom % 2;
    replyValid <= 1'b1;
    @(posedge clk);
    t = cyc * 12 / 50;
    cmp(timerValue, t);
    replyValid <= 1'b0;
    i = 0;
    while (HOST.q.size() < n + 8 && i < 400) begin
      @(posedge clk);
      i++;
    end
    if (i == 400) begin
      cmp(48'h1, 48'h0);
      hung = 1'b1;
      return;
    end
    cmp(HOST.q.pop_front(), 8'h31 + (k > 1 ? 2 : k));
    g = 48'h0;
    repeat (6) g = {g[39:0], HOST.q.pop_front()};
    if (timeKnown) cmp(g, t);
    else cmp(g, 48'h0);
    cmp(HOST.q.pop_front(), strengthKnown ? s : 8'hFF);
    for (i = 0; i < n; i++) cmp(HOST.q.pop_front(), dataByte(k, d[111:0], i));
  endtask
  initial begin
    void'($urandom(32'hFB4F));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int j = 0; j < 4; j++) if (!hung) frame(j, {16{8'h1A}}, 8'h1A);
    repeat (25) if (!hung) frame($urandom % 4,
      {$urandom, $urandom, $urandom, $urandom}, 8'($urandom));
    cmp(HOST.frames, 48'h1D);
    results;
  end
endmodule
